// File: tia_defs.svh
// Register offsets, field positions, reset values and timing counts of the AND reflex block.
`ifndef TIA_DEFS_SVH
`define TIA_DEFS_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define TIA_OFS_ENABLE    8'h00
`define TIA_OFS_OPA       8'h04
`define TIA_OFS_OPB       8'h08
`define TIA_OFS_OUTPUT    8'h0C
`define TIA_OFS_ACTION    8'h10
`define TIA_OFS_STATUS    8'h14
`define TIA_OFS_DOUT      8'h18

// ********************************************************************
// Field positions
// ********************************************************************
`define TIA_SRC_LSB       0
`define TIA_SRC_MSB       2
`define TIA_IDX_LSB       4
`define TIA_IDX_MSB       8
`define TIA_INV_BIT       12
`define TIA_CHV_BIT       0
`define TIA_ST_RESULT     0
`define TIA_ST_ENABLED    1
`define TIA_ST_NESTED     2

// ********************************************************************
// Reset values and timing counts
// ********************************************************************
`define TIA_RST_WORD      32'h0000_0000
`define TIA_RST_RESULT    1'b0
`define TIA_READ_WAIT     1

`endif

// File: tia_pkg.sv
// Types shared by the AND reflex block.
`default_nettype none
package tia_pkg;

  // Where an operand or the enable input takes its bit from.
  typedef enum logic [2:0] {
    TIA_SRC_CONST0,
    TIA_SRC_CONST1,
    TIA_SRC_ISLAND,
    TIA_SRC_VIRTUAL,
    TIA_SRC_ACTION,
    TIA_SRC_NESTED
  } tia_src_type;

  typedef struct packed {
    tia_src_type src;
    logic [4:0]  index;
    logic        invert;
  } tia_operand_type;

  typedef struct packed {
    logic       channel_valid;
    logic [4:0] channel;
    logic       invert;
  } tia_output_type;

  typedef enum logic [1:0] {
    TIA_BUS_IDLE,
    TIA_BUS_WRITE,
    TIA_BUS_READ
  } tia_bus_state_type;

endpackage : tia_pkg
`default_nettype wire

// File: tia_and_reflex.sv
// Two-input AND reflex block with its AHB-Lite register slave and output channel routing.
`timescale 1ns/1ps
`default_nettype none
`include "tia_defs.svh"

module tia_and_reflex #(
  parameter int N_CH = 32
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  input  wire logic [N_CH-1:0]   island_in,
  input  wire logic [N_CH-1:0]   virtual_out,
  input  wire logic              nested_in,
  output logic [N_CH-1:0]        dout,
  output logic                   stage_result
);

  // ********************************************************************
  // Parameter check
  // ********************************************************************
  // Channel and source indices are five bits wide, so at most 32 channels.
  if (N_CH < 1 || N_CH > 32)
  begin : gen_bad_width
    $error("N_CH must lie between 1 and 32.");
  end

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  // Island inputs come from pins; only the second stage is read by logic.
  logic [N_CH-1:0] island_meta;
  logic [N_CH-1:0] island_sync;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      island_meta <= '0;
      island_sync <= '0;
    end
    else
    begin
      island_meta <= island_in;
      island_sync <= island_meta;
    end
  end

  // ********************************************************************
  // Register file and bus slave state
  // ********************************************************************
  tia_pkg::tia_operand_type   cfg_enable;
  tia_pkg::tia_operand_type   cfg_opa;
  tia_pkg::tia_operand_type   cfg_opb;
  tia_pkg::tia_output_type    cfg_out;
  logic [31:0]                action_bits;
  tia_pkg::tia_bus_state_type bus_state;
  logic [7:0]                 bus_addr;

  tia_pkg::tia_operand_type   next_cfg_enable;
  tia_pkg::tia_operand_type   next_cfg_opa;
  tia_pkg::tia_operand_type   next_cfg_opb;
  tia_pkg::tia_output_type    next_cfg_out;
  logic [31:0]                next_action_bits;
  tia_pkg::tia_bus_state_type next_bus_state;
  logic [7:0]                 next_bus_addr;
  logic                       next_hreadyout;
  logic [31:0]                next_hrdata;

  logic                       result;
  logic                       enabled;
  logic [N_CH-1:0]            next_dout;
  logic                       next_result;
  logic                       next_enabled;

  function automatic tia_pkg::tia_operand_type tia_decode_operand(input logic [31:0] w);
    tia_pkg::tia_operand_type op;
    op.src    = tia_pkg::tia_src_type'(w[`TIA_SRC_MSB:`TIA_SRC_LSB]);
    op.index  = w[`TIA_IDX_MSB:`TIA_IDX_LSB];
    op.invert = w[`TIA_INV_BIT];
    return op;
  endfunction : tia_decode_operand

  function automatic logic [31:0] tia_encode_operand(input tia_pkg::tia_operand_type op);
    logic [31:0] w;
    w                              = 32'h0000_0000;
    w[`TIA_SRC_MSB:`TIA_SRC_LSB]   = op.src;
    w[`TIA_IDX_MSB:`TIA_IDX_LSB]   = op.index;
    w[`TIA_INV_BIT]                = op.invert;
    return w;
  endfunction : tia_encode_operand

  // Picks the raw bit of a source; an island or virtual index beyond the channel count reads 0.
  function automatic logic tia_pick(
    input tia_pkg::tia_operand_type op,
    input logic [N_CH-1:0]          isl,
    input logic [N_CH-1:0]          virt,
    input logic [31:0]              act,
    input logic                     nest
  );
    logic bit_val;
    bit_val = 1'b0;
    unique case (op.src)
      tia_pkg::TIA_SRC_CONST0:  bit_val = 1'b0;
      tia_pkg::TIA_SRC_CONST1:  bit_val = 1'b1;
      tia_pkg::TIA_SRC_ISLAND:  bit_val = (int'(op.index) < N_CH) ? isl[op.index] : 1'b0;
      tia_pkg::TIA_SRC_VIRTUAL: bit_val = (int'(op.index) < N_CH) ? virt[op.index] : 1'b0;
      tia_pkg::TIA_SRC_ACTION:  bit_val = act[op.index];
      tia_pkg::TIA_SRC_NESTED:  bit_val = nest;
      // Codes 6 and 7 are unassigned and behave as a constant 0.
      default:                  bit_val = 1'b0;
    endcase
    return bit_val;
  endfunction : tia_pick

  // ********************************************************************
  // Bus slave: next values
  // ********************************************************************
  // Writes finish with no wait state. Reads take one wait state so that a
  // write in the data phase just before is already visible.
  logic        addr_take;
  logic [31:0] read_word;

  always_comb
  begin
    addr_take = hsel && hready && htrans[1];

    read_word = 32'h0000_0000;
    unique case (bus_addr)
      `TIA_OFS_ENABLE: read_word = tia_encode_operand(cfg_enable);
      `TIA_OFS_OPA:    read_word = tia_encode_operand(cfg_opa);
      `TIA_OFS_OPB:    read_word = tia_encode_operand(cfg_opb);
      `TIA_OFS_OUTPUT:
      begin
        read_word[`TIA_CHV_BIT]               = cfg_out.channel_valid;
        read_word[`TIA_IDX_MSB:`TIA_IDX_LSB]  = cfg_out.channel;
        read_word[`TIA_INV_BIT]               = cfg_out.invert;
      end
      `TIA_OFS_ACTION: read_word = action_bits;
      `TIA_OFS_STATUS:
      begin
        read_word[`TIA_ST_RESULT]  = result;
        read_word[`TIA_ST_ENABLED] = enabled;
        read_word[`TIA_ST_NESTED]  = nested_in;
      end
      `TIA_OFS_DOUT:   read_word[N_CH-1:0] = dout;
      default:         read_word = 32'h0000_0000;
    endcase

    next_cfg_enable  = cfg_enable;
    next_cfg_opa     = cfg_opa;
    next_cfg_opb     = cfg_opb;
    next_cfg_out     = cfg_out;
    next_action_bits = action_bits;
    next_bus_state   = bus_state;
    next_bus_addr    = bus_addr;
    next_hreadyout   = 1'b1;
    next_hrdata      = hrdata;

    unique case (bus_state)
      tia_pkg::TIA_BUS_IDLE,
      tia_pkg::TIA_BUS_WRITE:
      begin
        if (bus_state == tia_pkg::TIA_BUS_WRITE)
        begin
          unique case (bus_addr)
            `TIA_OFS_ENABLE: next_cfg_enable = tia_decode_operand(hwdata);
            `TIA_OFS_OPA:    next_cfg_opa = tia_decode_operand(hwdata);
            `TIA_OFS_OPB:    next_cfg_opb = tia_decode_operand(hwdata);
            `TIA_OFS_OUTPUT:
            begin
              next_cfg_out.channel_valid = hwdata[`TIA_CHV_BIT];
              next_cfg_out.channel       = hwdata[`TIA_IDX_MSB:`TIA_IDX_LSB];
              next_cfg_out.invert        = hwdata[`TIA_INV_BIT];
            end
            // The fieldbus master keeps writing its bits even for a taken channel.
            `TIA_OFS_ACTION: next_action_bits = hwdata;
            // Status, output image and unmapped offsets ignore writes.
            default:         next_action_bits = action_bits;
          endcase
        end
        next_bus_state = tia_pkg::TIA_BUS_IDLE;
        if (addr_take)
        begin
          next_bus_addr = haddr[7:0];
          if (haddr[31:8] != 24'h00_0000)
          begin
            next_bus_addr = 8'hFF;
          end
          if (hwrite)
          begin
            next_bus_state = tia_pkg::TIA_BUS_WRITE;
          end
          else
          begin
            next_bus_state = tia_pkg::TIA_BUS_READ;
            next_hreadyout = 1'b0;
          end
        end
      end
      tia_pkg::TIA_BUS_READ:
      begin
        next_hrdata    = read_word;
        next_bus_state = tia_pkg::TIA_BUS_IDLE;
      end
      default:
      begin
        next_bus_state = tia_pkg::TIA_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cfg_enable  <= tia_pkg::tia_operand_type'(`TIA_RST_WORD);
      cfg_opa     <= tia_pkg::tia_operand_type'(`TIA_RST_WORD);
      cfg_opb     <= tia_pkg::tia_operand_type'(`TIA_RST_WORD);
      cfg_out     <= tia_pkg::tia_output_type'(`TIA_RST_WORD);
      action_bits <= `TIA_RST_WORD;
      bus_state   <= tia_pkg::TIA_BUS_IDLE;
      bus_addr    <= 8'h00;
      hreadyout   <= 1'b1;
      hrdata      <= `TIA_RST_WORD;
      hresp       <= 1'b0;
    end
    else
    begin
      cfg_enable  <= next_cfg_enable;
      cfg_opa     <= next_cfg_opa;
      cfg_opb     <= next_cfg_opb;
      cfg_out     <= next_cfg_out;
      action_bits <= next_action_bits;
      bus_state   <= next_bus_state;
      bus_addr    <= next_bus_addr;
      hreadyout   <= next_hreadyout;
      hrdata      <= next_hrdata;
      hresp       <= 1'b0;
    end
  end

  // ********************************************************************
  // Reflex evaluation: next values
  // ********************************************************************
  logic operand_a;
  logic operand_b;
  logic and_value;

  always_comb
  begin
    // Each operand is a single bit taken from its selected source.
    operand_a = tia_pick(cfg_opa, island_sync, virtual_out, action_bits, nested_in);
    operand_b = tia_pick(cfg_opb, island_sync, virtual_out, action_bits, nested_in);
    // Independent input inversions cover the four truth tables at once.
    and_value = (operand_a ^ cfg_opa.invert) & (operand_b ^ cfg_opb.invert);
    // The enable input never passes its inversion bit; only the source counts.
    next_enabled = tia_pick(cfg_enable, island_sync, virtual_out, action_bits,
                            nested_in);
    // A disabled block freezes; the next enabled edge uses current operands.
    if (next_enabled)
    begin
      next_result = and_value ^ cfg_out.invert;
    end
    else
    begin
      next_result = result;
    end
  end

  // ********************************************************************
  // Output channel routing
  // ********************************************************************
  // Without a selected channel the block acts as a first nested stage and
  // only stage_result carries its value.
  genvar ch;
  for (ch = 0; ch < N_CH; ch++)
  begin : gen_channel
    always_comb
    begin
      if (cfg_out.channel_valid && (int'(cfg_out.channel) == ch))
      begin
        next_dout[ch] = next_result;
      end
      else
      begin
        next_dout[ch] = action_bits[ch];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      result       <= `TIA_RST_RESULT;
      enabled      <= 1'b0;
      dout         <= '0;
      stage_result <= `TIA_RST_RESULT;
    end
    else
    begin
      result       <= next_result;
      enabled      <= next_enabled;
      dout         <= next_dout;
      stage_result <= next_result;
    end
  end

  // hsize is accepted for every access; only whole words are served.
  logic unused_inputs;
  assign unused_inputs = ^{hsize, htrans[0], haddr[1:0]};

endmodule : tia_and_reflex
`default_nettype wire

// File: tia_and_reflex_sva.sv
// Checker of bus timing and output stability of the AND reflex block.
`timescale 1ns/1ps
`default_nettype none
module tia_and_reflex_sva #(
  parameter int N_CH = 32
) (
  input wire logic            core_clk,
  input wire logic            reset,
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic            hready,
  input wire logic            hreadyout,
  input wire logic [31:0]     hrdata,
  input wire logic            hresp,
  input wire logic [N_CH-1:0] island_in,
  input wire logic [N_CH-1:0] virtual_out,
  input wire logic            nested_in,
  input wire logic [N_CH-1:0] dout,
  input wire logic            stage_result
);
  logic       take;
  logic [2:0] quiet;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  assign take = hsel && hready && htrans[1];
  // Island inputs need three edges to reach the outputs, so four quiet edges prove a freeze.
  always_ff @(posedge core_clk)
  begin
    if (reset || take || !$stable(island_in) || !$stable(virtual_out) || !$stable(nested_in))
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  end
  AST_HRESP_OKAY: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  AST_RESET_CLEAR: assert property ($fell(reset) |-> !stage_result && dout == '0)
    else $error("outputs not cleared by reset");
  AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write inserted a wait");
  AST_UNMAPPED_ZERO: assert property (take && !hwrite && haddr[31:8] != 24'h0
    |=> ##1 hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (!$stable(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("hrdata moved outside a read");
  AST_LOW_ONLY_READ: assert property ($fell(hreadyout) |-> $past(take && !hwrite))
    else $error("wait state without a read");
  AST_QUIET_STABLE: assert property (quiet >= 3'h4 |->
    $stable(stage_result) && $stable(dout))
    else $error("output moved with no cause");
endmodule : tia_and_reflex_sva
bind tia_and_reflex tia_and_reflex_sva #(.N_CH(N_CH)) u_sva (
  .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .island_in(island_in), .virtual_out(virtual_out), .nested_in(nested_in), .dout(dout),
  .stage_result(stage_result));
`default_nettype wire

// File: tia_island_model.sv
// Model of the island inputs, virtual outputs and first nested stage feeding the block.
`timescale 1ns/1ps
`default_nettype none
module tia_island_model #(
  parameter int N_CH = 32
) (
  input wire logic            core_clk,
  input wire logic            stall,
  input wire logic [N_CH-1:0] req_isl,
  input wire logic [N_CH-1:0] req_virt,
  input wire logic            req_nest,
  output logic [N_CH-1:0]     island_in,
  output logic [N_CH-1:0]     virtual_out,
  output logic                nested_in
);
  // A stalled island module is slow to report and keeps its last pin image.
  always_ff @(posedge core_clk)
  begin
    if (!stall)
      island_in <= req_isl;
    virtual_out <= req_virt;
    nested_in <= req_nest;
  end
endmodule : tia_island_model
`default_nettype wire

// File: tb.sv
// Self-checking testbench of the AND reflex block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        core_clk, reset, hsel, hwrite, stall, req_nest, hreadyout, hresp;
  logic        nested_in, stage_result, e;
  logic [31:0] haddr, hwdata, hrdata, dout, req_isl, req_virt, island_in, virtual_out, q;
  logic [1:0]  htrans, v;
  logic [2:0]  hsize, k;
  int          n_fail, tests_run, cyc;
  tia_and_reflex dut (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .island_in(island_in),
    .virtual_out(virtual_out), .nested_in(nested_in), .dout(dout), .stage_result(stage_result));
  tia_island_model u_far (.core_clk(core_clk), .stall(stall), .req_isl(req_isl),
    .req_virt(req_virt), .req_nest(req_nest), .island_in(island_in),
    .virtual_out(virtual_out), .nested_in(nested_in));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // The master never assumes a latency; a wait ends when hreadyout is high, or at the cycle ceiling.
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask : xfer
  task automatic st;
    repeat (5) @(posedge core_clk);
  endtask : st
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end
  initial
  begin
    {reset, hsel, hsize} <= {2'b11, 3'h2};
    {haddr, htrans, hwrite, hwdata, stall, req_isl, req_virt, req_nest} <= '0;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    xfer(32'h0, 1'b0, 32'h0);
    chk(q, 32'h0);
    xfer(32'h100, 1'b0, 32'h0);
    chk(q, 32'h0);
    chk(stage_result, 1'b0);
    chk(dout, 32'h0);
    $display("test reset done");
    xfer(32'h0, 1'b1, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      k = i[2:0];
      xfer(32'h4, 1'b1, {19'h0, k[0], 9'h0, 3'h3});
      xfer(32'h8, 1'b1, {19'h0, k[1], 7'h0, 1'b1, 4'h3});
      xfer(32'hC, 1'b1, {19'h0, k[2], 3'h0, 5'h3, 3'h0, 1'b1});
      for (int j = 0; j < 4; j++)
      begin
        v = j[1:0];
        req_virt <= {30'h0, v};
        st();
        e = ((v[0] ^ k[0]) & (v[1] ^ k[1])) ^ k[2];
        chk({stage_result, dout[3]}, {e, e});
      end
    end
    $display("test truth tables done");
    xfer(32'h10, 1'b1, 32'hA5A5_A5A5);
    st();
    chk(dout, 32'hA5A5_A5AD);
    xfer(32'h10, 1'b0, 32'h0);
    chk(q, 32'hA5A5_A5A5);
    xfer(32'h18, 1'b0, 32'h0);
    chk(q, 32'hA5A5_A5AD);
    xfer(32'h14, 1'b0, 32'h0);
    chk(q[0], 1'b1);
    $display("test channel done");
    xfer(32'h0, 1'b1, 32'h4);
    req_virt <= 32'h0;
    st();
    chk(stage_result, 1'b0);
    xfer(32'h10, 1'b1, 32'hA5A5_A5A4);
    req_virt <= 32'h3;
    st();
    chk(stage_result, 1'b0);
    xfer(32'h10, 1'b1, 32'hA5A5_A5A5);
    st();
    chk(stage_result, 1'b1);
    xfer(32'h0, 1'b1, 32'h0);
    req_virt <= 32'h0;
    st();
    chk(stage_result, 1'b1);
    $display("test enable done");
    xfer(32'h0, 1'b1, 32'h1);
    xfer(32'h4, 1'b1, 32'h22);
    xfer(32'h8, 1'b1, 32'h5);
    xfer(32'hC, 1'b1, 32'h0);
    req_isl <= 32'h4;
    req_nest <= 1'b1;
    st();
    chk({stage_result, dout[3]}, 2'b10);
    stall <= 1'b1;
    req_isl <= 32'h0;
    st();
    chk(stage_result, 1'b1);
    stall <= 1'b0;
    st();
    chk(stage_result, 1'b0);
    req_isl <= 32'h4;
    xfer(32'h8, 1'b1, 32'h4);
    st();
    chk(stage_result, 1'b1);
    xfer(32'h8, 1'b1, 32'h0);
    st();
    chk(stage_result, 1'b0);
    $display("test sources done");
    // A reset in mid-run must clear outputs that stand at nonzero values.
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk(dout, 32'h0);
    xfer(32'h10, 1'b0, 32'h0);
    chk(q, 32'h0);
    $display("test mid-run reset done");
    results();
  end
endmodule : tb
`default_nettype wire
